// File: design/rdc_cmd_top.sv
// Purpose: serves flash read, image check and check-then-install commands
// Assumes: block size and block count are powers of two
// Notes: command bytes in on rx_*, response bytes out on tx_*
`timescale 1ns/10ps
`include "rdc_params.svh"
module rdc_cmd_top #(
    parameter int NUM_BLOCKS = 128,
    parameter int BLOCK_SIZE = 512,
    parameter int INSTALL_CYCLES = `RDC_INSTALL_MS * `RDC_CLK_KHZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    // request stream
    input wire logic rx_valid,
    input wire rdc_pkg::rdc_byte_t rx_data,
    input wire logic rx_last,
    input wire logic rx_unicast,
    input wire rdc_pkg::rdc_byte_t rx_src_ep,
    output logic rx_ready,
    // response stream
    output logic tx_valid,
    output rdc_pkg::rdc_byte_t tx_data,
    output logic tx_last,
    output rdc_pkg::rdc_byte_t tx_dst_ep,
    input wire logic tx_ready,
    // flash write path from the write handler
    input wire logic fl_wr_en,
    input wire logic [$clog2(NUM_BLOCKS)+$clog2(BLOCK_SIZE)-1:0] fl_wr_addr,
    input wire rdc_pkg::rdc_byte_t fl_wr_data,
    // image checker pin and reset request
    input wire logic image_ok_pin,
    output logic dev_reset_req,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import rdc_pkg::*;

    localparam int BW = $clog2(BLOCK_SIZE);
    localparam int NBW = $clog2(NUM_BLOCKS);
    localparam int AW = NBW + BW;

    rdc_state_e st;
    rdc_byte_t cmd;
    rdc_word_t blk;
    rdc_word_t off;
    rdc_word_t cnt;
    logic [3:0] rx_idx;
    logic ucast;
    logic enable;
    logic img_meta;
    logic img_ok;
    logic [55:0] resp_sr;
    logic [3:0] hdr_left;
    rdc_word_t data_left;
    rdc_word_t rd_ptr;
    rdc_word_t resp_cnt;
    logic [31:0] inst_timer;
    logic [31:0] served;
    logic rx_fire;
    logic tx_fire;
    logic rd_err;

    rdc_mem_if #(.AW(AW)) mif ();

    rdc_flash_mem #(.AW(AW)) u_mem (
        .sys_clk(sys_clk),
        .ce(ce),
        .wr_en(fl_wr_en),
        .wr_addr(fl_wr_addr),
        .wr_data(fl_wr_data),
        .rp(mif.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // handshakes and checks

    // traffic is refused outright while installing
    assign rx_ready = (st == ST_IDLE);
    assign rx_fire = rx_valid && rx_ready && ce;
    assign tx_valid = (st == ST_HDR) || (st == ST_DATA);
    assign tx_fire = tx_valid && tx_ready && ce;
    assign tx_last = ((st == ST_HDR) && (hdr_left == 4'h0) && (data_left == 16'h0000))
        || ((st == ST_DATA) && (data_left == 16'h0001));
    // one request may touch one existing block only
    assign rd_err = (blk >= 16'(NUM_BLOCKS))
        || (({1'b0, off} + {1'b0, cnt}) > 17'(BLOCK_SIZE));
    assign mif.rd_en = (st == ST_FETCH) && ce;
    assign mif.rd_addr = {blk[NBW-1:0], rd_ptr[BW-1:0]};

    ////////////////////////////////////////////////////////////////////////
    // image status pin, asynchronous to us

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            img_meta <= 1'b0;
            img_ok <= 1'b0;
        end
        else if (ce)
        begin
            img_meta <= image_ok_pin;
            img_ok <= img_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rx_idx <= 4'h0;
            cmd <= 8'h00;
            blk <= 16'h0000;
            off <= 16'h0000;
            cnt <= 16'h0000;
            ucast <= 1'b0;
            tx_dst_ep <= 8'h00;
        end
        else if (rx_fire)
        begin
            // fields in order, big endian; bytes beyond the header are dropped
            case (rx_idx)
                4'h0:
                begin
                    cmd <= rx_data;
                    blk <= 16'h0000;
                    off <= 16'h0000;
                    cnt <= 16'h0000;
                end
                4'h2: blk[15:8] <= rx_data;
                4'h3: blk[7:0] <= rx_data;
                4'h4: off[15:8] <= rx_data;
                4'h5: off[7:0] <= rx_data;
                4'h6: cnt[15:8] <= rx_data;
                4'h7: cnt[7:0] <= rx_data;
                default: ;
            endcase
            if (rx_last)
            begin
                rx_idx <= 4'h0;
                ucast <= rx_unicast;
                tx_dst_ep <= rx_src_ep;
            end
            else if (rx_idx != 4'hF)
            begin
                rx_idx <= rx_idx + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st <= ST_IDLE;
            tx_data <= 8'h00;
            resp_sr <= 56'h00000000000000;
            hdr_left <= 4'h0;
            data_left <= 16'h0000;
            resp_cnt <= 16'h0000;
            rd_ptr <= 16'h0000;
            inst_timer <= 32'h00000000;
            dev_reset_req <= 1'b0;
        end
        else if (ce)
        begin
            dev_reset_req <= 1'b0;
            case (st)
                ST_IDLE:
                begin
                    if (rx_fire && rx_last)
                    begin
                        st <= ST_DECODE;
                    end
                end
                ST_DECODE:
                begin
                    hdr_left <= `RDC_HDR_LAST;
                    rd_ptr <= off;
                    // broadcasts and foreign codes get no answer here
                    if (!enable || !ucast)
                    begin
                        st <= ST_IDLE;
                    end
                    else if (cmd == `RDC_CMD_READ)
                    begin
                        st <= ST_HDR;
                        tx_data <= `RDC_RSP_READ;
                        resp_sr <= {(rd_err ? `RDC_STAT_ERR : `RDC_STAT_OK), blk, off,
                            (rd_err ? 16'h0000 : cnt)};
                        data_left <= rd_err ? 16'h0000 : cnt;
                        resp_cnt <= rd_err ? 16'h0000 : cnt;
                    end
                    else if (cmd == `RDC_CMD_CHECK)
                    begin
                        st <= ST_HDR;
                        tx_data <= `RDC_RSP_CHECK;
                        resp_sr <= {(img_ok ? `RDC_STAT_OK : `RDC_STAT_ERR),
                            48'h000000000000};
                        data_left <= 16'h0000;
                        resp_cnt <= 16'h0000;
                    end
                    else if (cmd == `RDC_CMD_INSTALL && img_ok)
                    begin
                        st <= ST_INSTALL;
                        inst_timer <= 32'(INSTALL_CYCLES);
                    end
                    else if (cmd == `RDC_CMD_INSTALL)
                    begin
                        st <= ST_HDR;
                        tx_data <= `RDC_RSP_INSTALL;
                        resp_sr <= {`RDC_STAT_ERR, 48'h000000000000};
                        data_left <= 16'h0000;
                        resp_cnt <= 16'h0000;
                    end
                    else
                    begin
                        st <= ST_IDLE;
                    end
                end
                ST_HDR:
                begin
                    if (tx_fire)
                    begin
                        if (hdr_left != 4'h0)
                        begin
                            tx_data <= resp_sr[55:48];
                            resp_sr <= {resp_sr[47:0], 8'h00};
                            hdr_left <= hdr_left - 4'h1;
                        end
                        else if (data_left != 16'h0000)
                        begin
                            st <= ST_FETCH;
                        end
                        else
                        begin
                            st <= ST_IDLE;
                        end
                    end
                end
                ST_FETCH:
                begin
                    st <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    // store answers one cycle after the fetch
                    tx_data <= mif.rd_data;
                    st <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (tx_fire)
                    begin
                        data_left <= data_left - 16'h0001;
                        rd_ptr <= rd_ptr + 16'h0001;
                        st <= (data_left == 16'h0001) ? ST_IDLE : ST_FETCH;
                    end
                end
                ST_INSTALL:
                begin
                    // no answer for a good image: the device resets instead
                    if (inst_timer <= 32'h00000001)
                    begin
                        dev_reset_req <= 1'b1;
                        st <= ST_IDLE;
                    end
                    else
                    begin
                        inst_timer <= inst_timer - 32'h00000001;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            enable <= `RDC_CTRL_RST;
        end
        else if (ce && reg_wr && reg_addr == `RDC_REG_CTRL)
        begin
            enable <= reg_wdata[0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            served <= 32'h00000000;
        end
        else if (ce && reg_wr && reg_addr == `RDC_REG_COUNT)
        begin
            served <= 32'h00000000;
        end
        else if (ce && st == ST_DECODE && enable && ucast)
        begin
            served <= served + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 32'h00000000;
        end
        else if (ce)
        begin
            reg_rdata <= 32'h00000000;
            if (reg_rd && reg_addr == `RDC_REG_CTRL)
            begin
                reg_rdata[0] <= enable;
            end
            else if (reg_rd && reg_addr == `RDC_REG_STATUS)
            begin
                reg_rdata[`RDC_ST_BUSY] <= (st != ST_IDLE);
                reg_rdata[`RDC_ST_IMG] <= img_ok;
                reg_rdata[`RDC_ST_INST] <= (st == ST_INSTALL);
            end
            else if (reg_rd && reg_addr == `RDC_REG_COUNT)
            begin
                reg_rdata <= served;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    rdc_word_t sent;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || st == ST_DECODE)
        begin
            sent <= 16'h0000;
        end
        else if (tx_fire && st == ST_DATA)
        begin
            sent <= sent + 16'h0001;
        end
    end

    property p_read_code;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_DECODE && ce && enable && ucast && cmd == `RDC_CMD_READ)
            |=> (st == ST_HDR && tx_data == `RDC_RSP_READ);
    endproperty
    a_read_code: assert property (p_read_code) else $error("read response code wrong");

    property p_check_code;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_DECODE && ce && enable && ucast && cmd == `RDC_CMD_CHECK)
            |=> (tx_data == `RDC_RSP_CHECK && resp_sr[48] == !$past(img_ok));
    endproperty
    a_check_code: assert property (p_check_code) else $error("check response wrong");

    property p_bcast_silent;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_DECODE && !ucast) |=> (st == ST_IDLE) ##1 !tx_valid;
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("answered broadcast");

    property p_err_nodata;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_DECODE && ce && enable && ucast && cmd == `RDC_CMD_READ && rd_err)
            |=> (data_left == 16'h0000 && resp_sr[48] && resp_cnt == 16'h0000);
    endproperty
    a_err_nodata: assert property (p_err_nodata) else $error("error read carries data");

    property p_install_quiet;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_INSTALL) |-> (!rx_ready && !tx_valid);
    endproperty
    a_install_quiet: assert property (p_install_quiet)
        else $error("traffic during install");

    property p_install_reset;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_INSTALL && ce && inst_timer == 32'h00000001) |=> dev_reset_req;
    endproperty
    a_install_reset: assert property (p_install_reset)
        else $error("install did not reset");

    property p_valid_no_reply;
        @(posedge sys_clk) disable iff (!rst_b)
        (st == ST_DECODE && ce && enable && ucast && cmd == `RDC_CMD_INSTALL && img_ok)
            |=> (st == ST_INSTALL) ##1 !tx_valid;
    endproperty
    a_valid_no_reply: assert property (p_valid_no_reply)
        else $error("replied to good image");

    property p_count_match;
        @(posedge sys_clk) disable iff (!rst_b)
        (tx_fire && tx_last) |-> (st == ST_HDR || sent + 16'h0001 == resp_cnt);
    endproperty
    a_count_match: assert property (p_count_match) else $error("byte count mismatch");

    c_read: cover property (@(posedge sys_clk) tx_fire && tx_last && st == ST_DATA);
    c_check: cover property (@(posedge sys_clk) st == ST_HDR && tx_data == `RDC_RSP_CHECK);
    c_install: cover property (@(posedge sys_clk) dev_reset_req);
    c_error: cover property (@(posedge sys_clk) st == ST_DECODE && rd_err && cmd == `RDC_CMD_READ);
endmodule // rdc_cmd_top

// File: pkg/rdc_params.svh
// Purpose: constants for the flash read and image check command handler
// Assumes: frames arrive as a byte stream with the command fields first
// Notes: multi-byte fields travel most significant byte first
// Contract
// - code 0x04 in the command code field means read general-purpose flash.
// - block number field selects which flash block is read.
// - start offset field gives the first byte read inside that block.
// - unicast read request gets a read response to its source endpoint.
// - read response carries code 0x84.
// - read response status bit 0 is one on error; higher bits reserved.
// - response echoes block number and start offset unchanged.
// - response byte count equals bytes placed in the data field.
// - response data are the bytes read from the block from the offset.
// - image check uses code 0x05, check-then-install uses 0x06.
// - either check command decides whether flash holds a valid image.
// - check-then-install with valid image resets and runs new firmware.
// - check request and response fields are zero and carry no data.
// - unicast image check request is answered at its source endpoint.
// - check response carries code 0x85.
// - check status bit 0 is one when image invalid, zero when valid.
// - check-then-install answers with 0x86 only for an invalid image.
// - install lasts up to eight seconds, ignores all traffic, ends in reset.
`ifndef RDC_PARAMS_SVH
`define RDC_PARAMS_SVH
`define RDC_CMD_READ 8'h04
`define RDC_CMD_CHECK 8'h05
`define RDC_CMD_INSTALL 8'h06
`define RDC_RSP_READ 8'h84
`define RDC_RSP_CHECK 8'h85
`define RDC_RSP_INSTALL 8'h86
`define RDC_STAT_OK 8'h00
`define RDC_STAT_ERR 8'h01
`define RDC_HDR_LAST 4'h7
`define RDC_REG_CTRL 8'h00
`define RDC_REG_STATUS 8'h04
`define RDC_REG_COUNT 8'h08
`define RDC_CTRL_RST 1'b1
`define RDC_ST_BUSY 0
`define RDC_ST_IMG 1
`define RDC_ST_INST 2
`define RDC_INSTALL_MS 8000
`define RDC_CLK_KHZ 125000
`endif

// File: pkg/rdc_pkg.sv
// Purpose: shared types of the command handler
// Assumes: nothing beyond the params header
// Notes: constants live in rdc_params.svh
package rdc_pkg;
    typedef logic [7:0] rdc_byte_t;
    typedef logic [15:0] rdc_word_t;
    typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_HDR, ST_FETCH, ST_WAIT, ST_DATA,
        ST_INSTALL} rdc_state_e;
endpackage

// File: pkg/rdc_mem_if.sv
// Purpose: read port between the handler and its flash store
// Assumes: read data appear one cycle after rd_en
// Notes: write side stays plain on the store
`timescale 1ns/10ps
interface rdc_mem_if #(parameter int AW = 16);
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output rd_en, output rd_addr, input rd_data);
    modport mem (input rd_en, input rd_addr, output rd_data);
endinterface

// File: design/rdc_flash_mem.sv
// Purpose: byte-wide general-purpose flash store
// Assumes: one write port from the write handler, one read port
// Notes: read data come out of a register
`timescale 1ns/10ps
module rdc_flash_mem #(
    parameter int AW = 16
) (
    // clock
    input wire logic sys_clk,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read side
    rdc_mem_if.mem rp
);
    logic [7:0] store [0:(1<<AW)-1];

    always_ff @(posedge sys_clk)
    begin
        if (ce && wr_en)
        begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (ce && rp.rd_en)
        begin
            rp.rd_data <= store[rp.rd_addr];
        end
    end
endmodule // rdc_flash_mem

// File: sim/rdc_req_model.sv
// Purpose: requesting node that sends command frames and collects answers
// Assumes: a frame is the eight command bytes, with no data bytes
// Notes: stall toggles tx_ready so that every answer byte is paced
`timescale 1ns/10ps
module rdc_req_model (
    // clock and pacing
    input wire logic sys_clk,
    input wire logic stall,
    // request side
    output logic rx_valid,
    output rdc_pkg::rdc_byte_t rx_data,
    output logic rx_last,
    output logic rx_unicast,
    output rdc_pkg::rdc_byte_t rx_src_ep,
    input wire logic rx_ready,
    // answer side
    input wire logic tx_valid,
    input wire rdc_pkg::rdc_byte_t tx_data,
    input wire logic tx_last,
    input wire rdc_pkg::rdc_byte_t tx_dst_ep,
    output logic tx_ready
);
    import rdc_pkg::*;
    rdc_byte_t rsp[$];
    rdc_byte_t last_ep;
    int n_done;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_unicast = 1'b0;
        rx_src_ep = 8'h00;
        tx_ready = 1'b0;
        n_done = 0;
        last_ep = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // entered just after a rising edge; each byte held until it is taken
    task automatic send(input rdc_byte_t code, input rdc_word_t blk, off, cnt,
        input logic uni, input rdc_byte_t ep);
        rdc_byte_t b[8];
        logic ok;
        // eight command bytes and no data, well inside any payload limit
        b = '{code, 8'h00, blk[15:8], blk[7:0], off[15:8], off[7:0], cnt[15:8],
            cnt[7:0]};
        for (int i = 0; i < 8; i++)
        begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            rx_last <= (i == 7);
            rx_unicast <= uni;
            rx_src_ep <= ep;
            do
            begin
                @(negedge sys_clk);
                ok = rx_ready;
                @(posedge sys_clk);
            end
            while (!ok);
        end
        // released valid, last, data and endpoint lines show a changed value; rx_unicast keeps the stale one
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~b[7];
        rx_src_ep <= ~ep;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready)
        begin
            rsp.push_back(tx_data);
            if (tx_last)
            begin
                n_done <= n_done + 1;
                last_ep <= tx_dst_ep;
            end
        end
    end
endmodule // rdc_req_model

// File: sim/tb_top.sv
// Purpose: self-checking bench for the flash read and image check handler
// Assumes: small block geometry and a short install count
// Notes: flash is preloaded through the write path before any request
`timescale 1ns/10ps
`include "rdc_params.svh"
module tb_top;
    import rdc_pkg::*;
    localparam int NB = 4;
    localparam int BS = 16;
    localparam int IC = 20;
    localparam rdc_byte_t EP = 8'h5C;
    logic sys_clk, rst_b, rx_valid, rx_last, rx_unicast, rx_ready;
    logic tx_valid, tx_last, tx_ready, fl_wr_en, image_ok_pin, dev_reset_req;
    logic reg_wr, reg_rd, stall, ce;
    rdc_byte_t rx_data, rx_src_ep, tx_data, tx_dst_ep, fl_wr_data;
    logic [5:0] fl_wr_addr;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int bad_count, tests_run;
    rdc_cmd_top #(.NUM_BLOCKS(NB), .BLOCK_SIZE(BS), .INSTALL_CYCLES(IC)) rdc_cmd_top_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_unicast(rx_unicast), .rx_src_ep(rx_src_ep), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_dst_ep(tx_dst_ep), .tx_ready(tx_ready),
        .fl_wr_en(fl_wr_en), .fl_wr_addr(fl_wr_addr), .fl_wr_data(fl_wr_data),
        .image_ok_pin(image_ok_pin), .dev_reset_req(dev_reset_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    rdc_req_model rdc_req_model_i (
        .sys_clk(sys_clk), .stall(stall),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_unicast(rx_unicast), .rx_src_ep(rx_src_ep), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_dst_ep(tx_dst_ep), .tx_ready(tx_ready));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic rdc_byte_t pat(input int a);
        return 8'hA5 ^ a[7:0];
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // waits a bounded time so that an unanswered request also returns
    task automatic req(input rdc_byte_t code, input rdc_word_t b, o, n, input logic uni);
        int n0;
        n0 = rdc_req_model_i.n_done;
        rdc_req_model_i.rsp.delete();
        rdc_req_model_i.send(code, b, o, n, uni, EP);
        for (int k = 0; k < 200 && rdc_req_model_i.n_done == n0; k++)
            @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic hdr(input rdc_byte_t code, st, input rdc_word_t b, o, n, input int nd);
        rdc_byte_t e[8];
        e = '{code, st, b[15:8], b[7:0], o[15:8], o[7:0], n[15:8], n[7:0]};
        chk(rdc_req_model_i.rsp.size(), 8 + nd);
        for (int i = 0; i < 8; i++)
            chk(rdc_req_model_i.rsp[i], e[i]);
        chk(rdc_req_model_i.last_ep, EP);
    endtask
    task automatic rd(input rdc_word_t b, o, n, input logic err);
        req(`RDC_CMD_READ, b, o, n, 1'b1);
        if (err)
            hdr(`RDC_RSP_READ, `RDC_STAT_ERR, b, o, 16'h0, 0);
        else
            hdr(`RDC_RSP_READ, `RDC_STAT_OK, b, o, n, n);
        for (int i = 0; i < n && !err; i++)
            chk(rdc_req_model_i.rsp[8 + i], pat(b * BS + o + i));
    endtask
    task automatic install_ok();
        int n, p;
        n = 0;
        p = 0;
        rdc_req_model_i.rsp.delete();
        rdc_req_model_i.send(`RDC_CMD_INSTALL, 16'h0, 16'h0, 16'h0, 1'b1, EP);
        for (int k = 0; k < IC + 100 && !(p > 0 && rx_ready); k++)
        begin
            @(negedge sys_clk);
            n += !rx_ready;
            p += dev_reset_req;
        end
        chk(n >= IC, 1);
        chk(p, 1);
        chk(rdc_req_model_i.rsp.size(), 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'b0;
        fl_wr_en = 1'b0;
        fl_wr_addr = 6'h00;
        fl_wr_data = 8'h00;
        image_ok_pin = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        stall = 1'b0;
        ce = 1'b1;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < NB * BS; a++)
        begin
            fl_wr_en <= 1'b1;
            fl_wr_addr <= a[5:0];
            fl_wr_data <= pat(a);
            @(posedge sys_clk);
        end
        fl_wr_en <= 1'b0;
        @(posedge sys_clk);
        rchk(`RDC_REG_CTRL, 32'h1);
        rchk(8'h0C, 32'h0);
        // a frozen block must ignore a register write
        ce <= 1'b0;
        reg_write(`RDC_REG_CTRL, 32'h0);
        ce <= 1'b1;
        rchk(`RDC_REG_CTRL, 32'h1);
        rd(16'h1, 16'h3, 16'h4, 1'b0);
        stall <= 1'b1;
        rd(16'h2, 16'h0, 16'h10, 1'b0);
        rd(16'h3, 16'hF, 16'h1, 1'b0);
        rd(16'h2, 16'h8, 16'h9, 1'b1);
        rd(16'h4, 16'h0, 16'h1, 1'b1);
        stall <= 1'b0;
        rd(16'h1, 16'h5, 16'h0, 1'b0);
        req(`RDC_CMD_READ, 16'h1, 16'h0, 16'h2, 1'b0);
        chk(rdc_req_model_i.rsp.size(), 0);
        req(`RDC_CMD_CHECK, 16'h0, 16'h0, 16'h0, 1'b1);
        hdr(`RDC_RSP_CHECK, 8'h01, 16'h0, 16'h0, 16'h0, 0);
        image_ok_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rchk(`RDC_REG_STATUS, 32'h2);
        reg_write(`RDC_REG_COUNT, 32'h0);
        req(`RDC_CMD_CHECK, 16'h0, 16'h0, 16'h0, 1'b1);
        hdr(`RDC_RSP_CHECK, 8'h00, 16'h0, 16'h0, 16'h0, 0);
        rchk(`RDC_REG_COUNT, 32'h1);
        reg_write(`RDC_REG_CTRL, 32'h0);
        req(`RDC_CMD_READ, 16'h1, 16'h0, 16'h1, 1'b1);
        chk(rdc_req_model_i.rsp.size(), 0);
        reg_write(`RDC_REG_CTRL, 32'h1);
        image_ok_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        req(`RDC_CMD_INSTALL, 16'h0, 16'h0, 16'h0, 1'b1);
        hdr(`RDC_RSP_INSTALL, 8'h01, 16'h0, 16'h0, 16'h0, 0);
        image_ok_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        install_ok();
        finish_test();
    end
    // the whole sequence needs under a thousand cycles
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end
endmodule // tb_top
